// [design/ffce_pin_sync.sv]
// two-flop synchronisers for the device pins and chain-input edge
`include "ffce_regs.svh"
module ffce_pin_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw pins
  input wire logic [4:0] pins,
  // synchronised view
  ffce_sync_if.src sif
);
  ffce_pkg::ffce_sync_t s_q;
  ffce_pkg::ffce_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.stage1 = pins;
    s_d.stage2 = s_q.stage1;
    s_d.chain_prev = s_q.stage2[`FFCE_PIN_WEN2];
    // token is a low pulse, so only the falling edge counts
    s_d.chain_fall = s_q.chain_prev & ~s_q.stage2[`FFCE_PIN_WEN2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{stage1: `FFCE_SYNC_INIT, stage2: `FFCE_SYNC_INIT,
        chain_prev: 1'b1, chain_fall: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.dev_reset = ~s_q.stage2[`FFCE_PIN_RESET];
  assign sif.wen2 = s_q.stage2[`FFCE_PIN_WEN2];
  assign sif.ren2 = s_q.stage2[`FFCE_PIN_REN2];
  assign sif.first_load = s_q.stage2[`FFCE_PIN_FL];
  assign sif.enhanced = ~s_q.stage2[`FFCE_PIN_ENHANCED_OPERATION_SELECT_N];
  assign sif.chain_fall = s_q.chain_fall;
endmodule // ffce_pin_sync

// [design/ffce_pkg.sv]
// types shared by the flag and expansion block
package ffce_pkg;

  typedef enum logic [1:0] {
    FFCE_STANDALONE = 2'b00,
    FFCE_PARALLEL = 2'b01,
    FFCE_MASTER = 2'b10,
    FFCE_SLAVE = 2'b11
  } ffce_group_t;

  typedef enum logic [2:0] {
    FFCE_SEL_CTRL = 3'h0,
    FFCE_SEL_AF = 3'h1,
    FFCE_SEL_AE = 3'h2,
    FFCE_SEL_STATUS = 3'h3,
    FFCE_SEL_COUNT = 3'h4,
    FFCE_SEL_NONE = 3'h7
  } ffce_sel_t;

  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
    logic chain_prev;
    logic chain_fall;
  } ffce_sync_t;

endpackage

// [design/ffce_regs.svh]
// register offsets, field positions and reset values of the flag block
`ifndef FFCE_REGS_SVH
`define FFCE_REGS_SVH

`define FFCE_CTRL_OFS 8'h00
`define FFCE_AF_OFS 8'h04
`define FFCE_AE_OFS 8'h08
`define FFCE_STATUS_OFS 8'h0C
`define FFCE_COUNT_OFS 8'h10

`define FFCE_CTRL_W 6
`define FFCE_CTRL_RST 6'h00
`define FFCE_CTRL_AF_SYNC 4
`define FFCE_CTRL_HF_LO 2
`define FFCE_CTRL_HF_HI 3
`define FFCE_HF_SYNC_W 2'h1
`define FFCE_HF_SYNC_R 2'h2

`define FFCE_OFFSET_RST 16'h007F
`define FFCE_WORD_W 18
`define FFCE_DEPTH 2048

`define FFCE_SYNC_INIT 5'h1E
`define FFCE_PIN_RESET 0
`define FFCE_PIN_WEN2 1
`define FFCE_PIN_REN2 2
`define FFCE_PIN_FL 3
`define FFCE_PIN_ENHANCED_OPERATION_SELECT_N 4

`endif

// [design/ffce_sync_if.sv]
// synchronised pin levels handed from the pin stage to the flag logic
interface ffce_sync_if;
  logic dev_reset;
  logic wen2;
  logic ren2;
  logic first_load;
  logic enhanced;
  logic chain_fall;
  modport src(output dev_reset, wen2, ren2, first_load, enhanced,
    chain_fall);
  modport dst(input dev_reset, wen2, ren2, first_load, enhanced,
    chain_fall);
endinterface

// [design/ffce_top.sv]
// write-side flags, grouping mode and write-token logic of the fifo
//
// Summary of operation
// - four pins choose grouping mode at reset
// - both second enables low: standalone
// - reset drives chain outputs high; master/slave
// - register words zero-filled to 18 bits
// - full flag low when fifo holds depth
// - writes ignored while full
// - full after exactly depth writes
// - full flag changes on write ticks only
// - almost-full from fill level versus offset
// - offset resets to 127, loadable to depth
// - almost-full after depth minus offset writes
// - compatible mode: set on write, clear read
// - control bit 4 syncs almost-full to writes
// - shared pin: half-full or write token
// - last location written: token pulse, stop
// - token received: active at next write
// - half-full above half the depth
// - half-full after half depth plus one
// - control bits 3:2 pick half-full side
// - third load write goes to control
//
// Our own choices: register access over APB and the placing of the registers.
`include "ffce_regs.svh"
module ffce_top #(
  parameter int DEPTH = `FFCE_DEPTH
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo write and read side, same clock
  input wire logic write_tick,
  input wire logic write_enable_n,
  input wire logic read_tick,
  input wire logic read_enable_n,
  input wire logic register_load_n,
  input wire logic [17:0] write_data,
  // device pins
  input wire logic reset_n,
  input wire logic write_chain_in_or_second_write_enable,
  input wire logic read_chain_in_or_second_read_enable,
  input wire logic first_load_or_rewind,
  input wire logic enhanced_operation_select_n,
  // flags and words
  output logic full_flag_n,
  output logic almost_full_flag_n,
  output logic write_chain_out_or_half_full,
  output logic read_chain_out_or_delayed_empty,
  output logic [17:0] output_word
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW:0] HALF_C = (AW + 1)'(DEPTH / 2);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);
  // a shallow build cannot hold the default offset; park it at full depth
  localparam logic [AW:0] OFS_RST = (AW + 1)'((DEPTH < `FFCE_OFFSET_RST) ?
    DEPTH : `FFCE_OFFSET_RST);

  typedef struct packed {
    ffce_pkg::ffce_group_t mode;
    logic enhanced;
    logic [`FFCE_CTRL_W-1:0] ctrl;
    logic [AW:0] af_off;
    logic [AW:0] ae_off;
    logic [AW:0] count;
    logic [AW-1:0] wptr;
    logic [1:0] wr_seq;
    logic [1:0] rd_seq;
    logic full_n;
    logic af_n;
    logic hf_n;
    logic wact;
    logic token_n;
    logic pin_q;
    logic [17:0] word;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ffce_state_t;

  ffce_sync_if sif ();
  ffce_state_t s_q;
  ffce_state_t s_d;
  logic cascade;
  logic wr_ok;
  logic rd_ok;
  logic ld_wr;
  logic ld_rd;
  logic [AW:0] cnt_d;

  ffce_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({enhanced_operation_select_n, first_load_or_rewind,
      read_chain_in_or_second_read_enable,
      write_chain_in_or_second_write_enable, reset_n}),
    .sif(sif)
  );

  function automatic ffce_pkg::ffce_sel_t reg_sel(logic [7:0] a);
    case (a)
      `FFCE_CTRL_OFS: reg_sel = ffce_pkg::FFCE_SEL_CTRL;
      `FFCE_AF_OFS: reg_sel = ffce_pkg::FFCE_SEL_AF;
      `FFCE_AE_OFS: reg_sel = ffce_pkg::FFCE_SEL_AE;
      `FFCE_STATUS_OFS: reg_sel = ffce_pkg::FFCE_SEL_STATUS;
      `FFCE_COUNT_OFS: reg_sel = ffce_pkg::FFCE_SEL_COUNT;
      default: reg_sel = ffce_pkg::FFCE_SEL_NONE;
    endcase
  endfunction

  // three-step load walk; control step only exists in enhanced mode
  function automatic logic [1:0] seq_next(logic [1:0] q, logic enh);
    seq_next = (q == 2'h0) ? 2'h1 : (q == 2'h1 && enh) ? 2'h2 : 2'h0;
  endfunction

  // zero-filled 18-bit view of a load-sequence register
  function automatic logic [17:0] seq_word(logic [1:0] q,
      ffce_state_t st);
    seq_word = (q == 2'h0) ? 18'(st.ae_off) :
      (q == 2'h1) ? 18'(st.af_off) : 18'(st.ctrl);
  endfunction

  // active-low flag: falls on a set edge, rises on a clear edge
  function automatic logic flag_next(logic cur_n, logic hit,
      logic set_ev, logic clr_ev);
    flag_next = (set_ev && hit) ? 1'b0 :
      (clr_ev && !hit) ? 1'b1 : cur_n;
  endfunction

  function automatic logic [AW:0] clamp_ofs(logic [31:0] v);
    clamp_ofs = (v > 32'(DEPTH)) ? DEPTH_C : v[AW:0];
  endfunction

  always_comb begin
    s_d = s_q;
    cascade = (s_q.mode == ffce_pkg::FFCE_MASTER) ||
      (s_q.mode == ffce_pkg::FFCE_SLAVE);
    ld_wr = write_tick && !write_enable_n && !register_load_n;
    ld_rd = read_tick && !read_enable_n && !register_load_n;
    // partner flags are active low: a high full flag lets us write
    wr_ok = write_tick && !write_enable_n && register_load_n &&
      s_q.full_n && s_q.wact &&
      (s_q.mode != ffce_pkg::FFCE_PARALLEL || sif.wen2);
    rd_ok = read_tick && !read_enable_n && register_load_n &&
      (s_q.count != '0) &&
      (s_q.mode != ffce_pkg::FFCE_PARALLEL || sif.ren2);
    cnt_d = s_q.count + (AW + 1)'(wr_ok) - (AW + 1)'(rd_ok);

    // one clock domain, so the opposite pointer needs no copy
    if (write_tick) begin
      s_d.full_n = (cnt_d != DEPTH_C);
    end
    if (s_q.enhanced && s_q.ctrl[`FFCE_CTRL_AF_SYNC]) begin
      s_d.af_n = flag_next(s_q.af_n, (DEPTH_C - cnt_d) <= s_q.af_off,
        write_tick, write_tick);
    end else begin
      s_d.af_n = flag_next(s_q.af_n, (DEPTH_C - cnt_d) <= s_q.af_off,
        write_tick, read_tick);
    end
    if (s_q.enhanced &&
        s_q.ctrl[`FFCE_CTRL_HF_HI:`FFCE_CTRL_HF_LO] == `FFCE_HF_SYNC_W) begin
      s_d.hf_n = flag_next(s_q.hf_n, cnt_d > HALF_C, write_tick,
        write_tick);
    end else if (s_q.enhanced &&
        s_q.ctrl[`FFCE_CTRL_HF_HI:`FFCE_CTRL_HF_LO] == `FFCE_HF_SYNC_R) begin
      s_d.hf_n = flag_next(s_q.hf_n, cnt_d > HALF_C, read_tick,
        read_tick);
    end else begin
      s_d.hf_n = flag_next(s_q.hf_n, cnt_d > HALF_C, write_tick,
        read_tick);
    end
    s_d.count = cnt_d;
    if (wr_ok) begin
      s_d.wptr = (s_q.wptr == LAST_C) ? '0 : s_q.wptr + AW'(1);
    end

    // write token around the ring
    s_d.token_n = 1'b1;
    if (cascade && wr_ok && s_q.wptr == LAST_C) begin
      s_d.token_n = 1'b0;
      s_d.wact = 1'b0;
    end
    // a token arriving with our last write still wins
    if (cascade && sif.chain_fall) begin
      s_d.wact = 1'b1;
    end
    s_d.pin_q = cascade ? s_d.token_n : s_d.hf_n;

    if (ld_wr) begin
      unique case (s_q.wr_seq)
        2'h0: s_d.ae_off = clamp_ofs(32'(write_data));
        2'h1: s_d.af_off = clamp_ofs(32'(write_data));
        2'h2: s_d.ctrl = write_data[`FFCE_CTRL_W-1:0];
        default: s_d.wr_seq = 2'h0;
      endcase
      s_d.wr_seq = seq_next(s_q.wr_seq, s_q.enhanced);
    end
    if (ld_rd) begin
      s_d.word = seq_word(s_q.rd_seq, s_q);
      s_d.rd_seq = seq_next(s_q.rd_seq, s_q.enhanced);
    end

    // apb: decode in setup, answer in the first access cycle
    s_d.pready = psel && !penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (psel && !penable && !s_q.pready) begin
      s_d.prdata = '0;
      s_d.pslverr = (reg_sel(paddr) == ffce_pkg::FFCE_SEL_NONE);
      unique case (reg_sel(paddr))
        ffce_pkg::FFCE_SEL_CTRL: s_d.prdata = 32'(s_q.ctrl);
        ffce_pkg::FFCE_SEL_AF: s_d.prdata = 32'(s_q.af_off);
        ffce_pkg::FFCE_SEL_AE: s_d.prdata = 32'(s_q.ae_off);
        ffce_pkg::FFCE_SEL_STATUS: s_d.prdata = 32'({s_q.enhanced,
          s_q.mode, s_q.wact, s_q.hf_n, s_q.af_n, s_q.full_n});
        ffce_pkg::FFCE_SEL_COUNT: s_d.prdata = 32'(s_q.count);
        ffce_pkg::FFCE_SEL_NONE: s_d.prdata = '0;
      endcase
    end
    if (psel && penable && s_q.pready && pwrite) begin
      unique case (reg_sel(paddr))
        ffce_pkg::FFCE_SEL_CTRL:
          s_d.ctrl = pwdata[`FFCE_CTRL_W-1:0];
        ffce_pkg::FFCE_SEL_AF: s_d.af_off = clamp_ofs(pwdata);
        ffce_pkg::FFCE_SEL_AE: s_d.ae_off = clamp_ofs(pwdata);
        ffce_pkg::FFCE_SEL_STATUS, ffce_pkg::FFCE_SEL_COUNT,
        ffce_pkg::FFCE_SEL_NONE: s_d.ae_off = s_d.ae_off;
      endcase
    end

    // device reset pin: capture the mode, park every flag
    if (sif.dev_reset) begin
      if (sif.wen2 && sif.ren2) begin
        s_d.mode = sif.first_load ? ffce_pkg::FFCE_SLAVE :
          ffce_pkg::FFCE_MASTER;
      end else if (sif.enhanced && sif.wen2 && !sif.ren2) begin
        s_d.mode = ffce_pkg::FFCE_PARALLEL;
      end else begin
        s_d.mode = ffce_pkg::FFCE_STANDALONE;
      end
      s_d.enhanced = sif.enhanced;
      s_d.wact = !(sif.wen2 && sif.ren2 && sif.first_load);
      s_d.ctrl = `FFCE_CTRL_RST;
      s_d.af_off = OFS_RST;
      s_d.ae_off = OFS_RST;
      s_d.count = '0;
      s_d.wptr = '0;
      s_d.wr_seq = 2'h0;
      s_d.rd_seq = 2'h0;
      s_d.full_n = 1'b1;
      s_d.af_n = 1'b1;
      s_d.hf_n = 1'b1;
      s_d.token_n = 1'b1;
      s_d.pin_q = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{mode: ffce_pkg::FFCE_STANDALONE, enhanced: 1'b0,
        ctrl: `FFCE_CTRL_RST, af_off: OFS_RST, ae_off: OFS_RST,
        count: '0, wptr: '0, wr_seq: 2'h0, rd_seq: 2'h0, full_n: 1'b1,
        af_n: 1'b1, hf_n: 1'b1, wact: 1'b1, token_n: 1'b1, pin_q: 1'b1,
        word: '0, pready: 1'b0, pslverr: 1'b0, prdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign full_flag_n = s_q.full_n;
  assign almost_full_flag_n = s_q.af_n;
  assign write_chain_out_or_half_full = s_q.pin_q;
  // read token is not modelled; the pin rests high
  assign read_chain_out_or_delayed_empty = s_q.token_n | 1'b1;
  assign output_word = s_q.word;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_write;
    cascade && wr_ok && s_q.wptr == LAST_C;
  endsequence
  sequence s_token_pulse;
    !write_chain_out_or_half_full && !s_q.wact;
  endsequence

  a_full_blocks_write: assert property (
    !full_flag_n && !rd_ok && !sif.dev_reset |=> $stable(s_q.count))
    else $error("write taken while full");
  a_pair_write_gate: assert property (
    s_q.mode == ffce_pkg::FFCE_PARALLEL && !sif.wen2 && !rd_ok &&
    !sif.dev_reset |=> $stable(s_q.count))
    else $error("write taken while partner full");
  a_full_at_depth: assert property (
    write_tick && cnt_d == DEPTH_C && !sif.dev_reset |=> !full_flag_n)
    else $error("full flag missed at depth");
  a_full_wtick_only: assert property (
    !write_tick && !sif.dev_reset |=> $stable(full_flag_n))
    else $error("full flag moved without write tick");
  a_af_sync_write: assert property (
    s_q.enhanced && s_q.ctrl[`FFCE_CTRL_AF_SYNC] && !write_tick &&
    !sif.dev_reset |=> $stable(almost_full_flag_n))
    else $error("synchronous almost-full moved off write tick");
  a_af_compat_clear: assert property (
    !s_q.enhanced && almost_full_flag_n && !write_tick &&
    !sif.dev_reset |=> almost_full_flag_n)
    else $error("almost-full set without write tick");
  a_token_pulse: assert property (
    s_last_write and (!sif.chain_fall && !sif.dev_reset) |=>
    s_token_pulse ##1
    write_chain_out_or_half_full)
    else $error("write token pulse wrong");
  a_token_accept: assert property (
    cascade && sif.chain_fall && !sif.dev_reset |=> s_q.wact)
    else $error("token not accepted");
  a_reset_outputs: assert property (
    sif.dev_reset |=> write_chain_out_or_half_full && full_flag_n &&
    almost_full_flag_n)
    else $error("outputs not parked high in reset");
  a_mode_held: assert property (
    !sif.dev_reset ##1 !sif.dev_reset |-> $stable(s_q.mode))
    else $error("grouping mode changed outside reset");
  a_ctrl_third: assert property (
    ld_wr && s_q.wr_seq == 2'h2 && !sif.dev_reset |=>
    s_q.wr_seq == 2'h0 && s_q.ctrl == $past(write_data[5:0]))
    else $error("third load write missed control");
  a_word_zero_fill: assert property (
    output_word[17:AW+1] == '0)
    else $error("unused word bits not zero");
endmodule // ffce_top

// [verification/ffce_far_side.sv]
// fifo-side tick driver and cascade neighbour for the flag block
module ffce_far_side (
  // clock
  input wire logic pclk,
  // fifo write and read ticks
  output logic write_tick,
  output logic write_enable_n,
  output logic read_tick,
  output logic read_enable_n,
  // previous device in the ring, or parallel partner flag
  output logic chain_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    write_tick = 1'b0;
    write_enable_n = 1'b1;
    read_tick = 1'b0;
    read_enable_n = 1'b1;
    chain_out = 1'b1;
  end

  task automatic idle();
    write_tick <= 1'b0;
    write_enable_n <= 1'b1;
    read_tick <= 1'b0;
    read_enable_n <= 1'b1;
  endtask

  // gap above zero makes a slow side; with no gap ticks stay up
  task automatic tick(input logic rd, input int n, input int gap,
      input logic en_n);
    for (int i = 0; i < n; i++) begin
      if (rd) begin
        read_tick <= 1'b1;
        read_enable_n <= en_n;
      end else begin
        write_tick <= 1'b1;
        write_enable_n <= en_n;
      end
      @(posedge pclk);
      if (gap > 0) begin
        idle();
        repeat (gap) @(posedge pclk);
      end
    end
    idle();
    @(posedge pclk);
  endtask

  // a parallel partner shows its full flag here
  task automatic set_chain(input logic v);
    chain_out <= v;
  endtask

  // one-cycle low token, then back to idle high
  task automatic token();
    chain_out <= 1'b0;
    @(posedge pclk);
    chain_out <= 1'b1;
    @(posedge pclk);
  endtask
endmodule // ffce_far_side

// [verification/ffce_top_test.sv]
// self-checking bench for the write-side flag and cascade block
`include "ffce_regs.svh"
module ffce_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 16;
  localparam int P = 4;
  localparam int OFS = (D < `FFCE_OFFSET_RST) ? D : `FFCE_OFFSET_RST;
  logic pclk, pready, pslverr, wtick, wen_n, rtick, ren_n, chain, e;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic load_n = 1'b1, reset_n = 1'b0, rd_chain_in = 1'b0;
  logic first_ld = 1'b0, enh_n = 1'b1;
  logic full_n, af_n, token_hf, rd_chain_out;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [17:0] wdata = 18'h00005, word;
  int error_cnt = 0, check_count = 0;
  logic [3:0] pins [4] = '{4'b0001, 4'b1000, 4'b1111, 4'b1101};
  logic [1:0] md [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

  ffce_top #(.DEPTH(D)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_tick(wtick), .write_enable_n(wen_n), .read_tick(rtick),
    .read_enable_n(ren_n), .register_load_n(load_n), .write_data(wdata),
    .reset_n(reset_n), .write_chain_in_or_second_write_enable(chain),
    .read_chain_in_or_second_read_enable(rd_chain_in),
    .first_load_or_rewind(first_ld), .enhanced_operation_select_n(enh_n),
    .full_flag_n(full_n), .almost_full_flag_n(af_n),
    .write_chain_out_or_half_full(token_hf),
    .read_chain_out_or_delayed_empty(rd_chain_out), .output_word(word));

  ffce_far_side far (.pclk(pclk), .write_tick(wtick),
    .write_enable_n(wen_n), .read_tick(rtick), .read_enable_n(ren_n),
    .chain_out(chain));

  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    check_count++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // one apb transfer; releases at the pready edge, watchdog bounds the wait
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pins_set(input logic [3:0] m);
    far.set_chain(m[3]);
    rd_chain_in <= m[2];
    first_ld <= m[1];
    enh_n <= m[0];
  endtask

  task automatic rst(input logic [3:0] m);
    pins_set(m);
    presetn <= 1'b0;
    reset_n <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    reset_n <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask

  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  initial begin
    rst(4'b0001);
    chk({full_n, af_n, token_hf, rd_chain_out}, 33'hF);
    apb(1'b0, `FFCE_AF_OFS, 32'h0);
    chk(r, OFS);
    apb(1'b0, `FFCE_CTRL_OFS, 32'h0);
    chk(r, 33'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({e, r}, {1'b1, 32'h0});
    load_n <= 1'b0;
    far.tick(1'b0, 2, 0, 1'b0);
    far.tick(1'b1, 1, 0, 1'b0);
    chk(word, 33'h5);
    load_n <= 1'b1;
    apb(1'b0, `FFCE_AF_OFS, 32'h0);
    chk(r, 33'h5);
    apb(1'b0, `FFCE_COUNT_OFS, 32'h0);
    chk(r, 33'h0);
    apb(1'b1, `FFCE_AF_OFS, P);
    apb(1'b0, `FFCE_AF_OFS, 32'h0);
    chk(r, P);
    far.tick(1'b0, D / 2, 1, 1'b0);
    chk(token_hf, 33'h1);
    far.tick(1'b0, 1, 0, 1'b0);
    chk(token_hf, 33'h0);
    far.tick(1'b0, D - P - D / 2 - 2, 0, 1'b0);
    chk(af_n, 33'h1);
    far.tick(1'b0, 1, 0, 1'b0);
    chk(af_n, 33'h0);
    far.tick(1'b0, P - 1, 0, 1'b0);
    chk(full_n, 33'h1);
    far.tick(1'b0, 1, 0, 1'b0);
    chk(full_n, 33'h0);
    far.tick(1'b0, 2, 0, 1'b0);
    apb(1'b0, `FFCE_COUNT_OFS, 32'h0);
    chk(r, D);
    far.tick(1'b1, 1, 0, 1'b0);
    chk({full_n, af_n}, 33'h0);
    far.tick(1'b0, 1, 0, 1'b1);
    chk(full_n, 33'h1);
    far.tick(1'b1, P, 2, 1'b0);
    chk(af_n, 33'h1);
    // the last entry leaves the device a cascade master
    for (int i = 0; i < 4; i++) begin
      rst(pins[i]);
      apb(1'b0, `FFCE_STATUS_OFS, 32'h0);
      chk(r[6:4], {~pins[i][0], md[i]});
      if (md[i][1]) chk(r[3], md[i] == 2'b10);
      pins_set(4'b0001);
      repeat (4) @(posedge pclk);
      apb(1'b0, `FFCE_STATUS_OFS, 32'h0);
      chk(r[6:4], {~pins[i][0], md[i]});
      pins_set(pins[i]);
      repeat (4) @(posedge pclk);
      // enhanced pair: control step of the load walk, then write gating
      if (i == 1) begin
        load_n <= 1'b0;
        wdata <= 18'h00010;
        far.tick(1'b0, 3, 0, 1'b0);
        far.tick(1'b1, 3, 0, 1'b0);
        chk(word, 33'h10);
        load_n <= 1'b1;
        apb(1'b0, `FFCE_CTRL_OFS, 32'h0);
        chk(r, 33'h10);
        far.set_chain(1'b0);
        repeat (4) @(posedge pclk);
        far.tick(1'b0, 1, 0, 1'b0);
        far.set_chain(1'b1);
        repeat (4) @(posedge pclk);
        far.tick(1'b0, 1, 0, 1'b0);
        apb(1'b0, `FFCE_COUNT_OFS, 32'h0);
        chk(r, 33'h1);
      end
    end
    far.tick(1'b0, D, 0, 1'b0);
    chk(token_hf, 33'h0);
    @(posedge pclk);
    chk(token_hf, 33'h1);
    far.tick(1'b1, 2, 0, 1'b0);
    far.tick(1'b0, 1, 0, 1'b0);
    chk(token_hf, 33'h1);
    apb(1'b0, `FFCE_STATUS_OFS, 32'h0);
    chk(r[3], 33'h0);
    apb(1'b0, `FFCE_COUNT_OFS, 32'h0);
    chk(r, D - 2);
    far.token();
    repeat (6) @(posedge pclk);
    apb(1'b0, `FFCE_STATUS_OFS, 32'h0);
    chk(r[3], 33'h1);
    far.tick(1'b0, 1, 0, 1'b0);
    apb(1'b0, `FFCE_COUNT_OFS, 32'h0);
    chk(r, D - 1);
    conclude();
  end
endmodule // ffce_top_test
